// ### verilog/ddr_dac_pkg.sv
/*
 * Shared constants and types for the interleaved DDR converter input.
 * Assumes a single core clock domain; the sample clock is sampled as data.
 */
`default_nettype none

package ddr_dac_pkg;

    // ************************************************************
    // Widths and timing
    // ************************************************************
    localparam int WORD_WIDTH_DEFAULT = 14;   // Allowed builds: 10, 12, 14
    localparam int WIDTH_NARROW       = 10;
    localparam int WIDTH_MID          = 12;
    localparam int WIDTH_WIDE         = 14;
    localparam int LATENCY_EDGES      = 3;    // 1.5 sample clocks, two edges each
    localparam logic SLEEP_PULL_LEVEL = 1'b1; // Undriven select reads high

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [0:0] {
        CHAN_A = 1'b0,
        CHAN_B = 1'b1
    } chan_t;

    typedef enum logic [0:0] {
        MODE_ACTIVE = 1'b0,
        MODE_SLEEP  = 1'b1
    } mode_t;

endpackage : ddr_dac_pkg

`default_nettype wire

// ### verilog/chan_load_if.sv
/*
 * Carrier from the input steering logic to one channel output stage.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface chan_load_if #(
    parameter int WIDTH = 14
) ();
    // Word to convert, load strobe and sleep level
    logic [WIDTH-1:0] word;
    logic             load;
    logic             sleep;

    modport src (output word, output load, output sleep);
    modport dst (input word, input load, input sleep);
endinterface : chan_load_if

`default_nettype wire

// ### verilog/chan_current_out.sv
/*
 * One converter channel output stage: turns an offset-binary word into
 * the sink codes of the positive and complementary current outputs.
 * Assumes load strobes come from the steering logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module chan_current_out
    import ddr_dac_pkg::*;
#(
    parameter int WIDTH = ddr_dac_pkg::WORD_WIDTH_DEFAULT
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // Steering side
    chan_load_if.dst              link,
    // Current sink codes
    output logic [WIDTH-1:0]      sink_pos,
    output logic [WIDTH-1:0]      sink_neg
);

    logic [WIDTH-1:0] pos_next;
    logic [WIDTH-1:0] neg_next;

    // Zeros sink full scale on the positive side, ones sink nothing
    assign pos_next = link.sleep ? '0 : (link.load ? ~link.word : sink_pos);
    assign neg_next = link.sleep ? '0 : (link.load ? link.word : sink_neg);

    // Output codes held between loads; zero current out of reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sink_pos <= '0;
            sink_neg <= '0;
        end else begin
            sink_pos <= pos_next;
            sink_neg <= neg_next;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    offset_binary_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (link.load && !link.sleep) |=>
            (sink_pos == ~$past(link.word)) && (sink_neg == $past(link.word)))
        else $error("Output codes do not follow offset binary word");

    sleep_zero_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        link.sleep [*2] |-> (sink_pos == '0) && (sink_neg == '0))
        else $error("Channel sinks current while asleep");

endmodule : chan_current_out

`default_nettype wire

// ### verilog/ddr_dac_input.sv
/*
 * Digital input of a dual-channel converter: one shared DDR bus carries
 * interleaved words for channels A and B, loaded on both sample clock
 * edges, plus the sleep select pin.
 * Assumes sample clock, bus and sleep pin are asynchronous to core_clk
 * and that the source keeps the word rate within what core_clk resolves.
 */
// Contract
// - Each rising and falling sample clock edge captures one new bus word.
// - Both channels share the bus in turn and each word goes to its channel.
// - Word width is a build choice of 10, 12 or 14 bits, one pair per bit.
// - The top bus bit is the word's MSB and bus bit zero its LSB.
// - Offset binary: zeros sink full scale on pos, ones none, neg opposite.
// - Sleep select low puts the device to sleep and high makes it active.
// - Sleep select has a pull-up, so an undriven pin means active mode.
// - A captured word reaches its output 1.5 sample clock cycles later.
// - Each channel runs at up to 500 million samples per second.
`timescale 1ns/1ps
`default_nettype none

module ddr_dac_input
    import ddr_dac_pkg::*;
#(
    parameter int WIDTH = ddr_dac_pkg::WORD_WIDTH_DEFAULT
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                nrst,
    // Sample clock pair
    input  wire logic                sample_clock_pos,
    input  wire logic                sample_clock_neg,
    // Shared DDR data bus, one pair per bit
    input  wire logic [WIDTH-1:0]    data_pos,
    input  wire logic [WIDTH-1:0]    data_neg,
    // Sleep select pin and whether anything drives it
    input  wire logic                sleep_select_n,
    input  wire logic                sleep_select_driven,
    // Channel A current sink codes
    output logic [WIDTH-1:0]         chan_a_current_pos,
    output logic [WIDTH-1:0]         chan_a_current_neg,
    // Channel B current sink codes
    output logic [WIDTH-1:0]         chan_b_current_pos,
    output logic [WIDTH-1:0]         chan_b_current_neg,
    // Mode status
    output logic                     sleep_active
);

    localparam int SYNC_W = 2 * WIDTH + 4;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] pins_raw;

    assign pins_raw = {sample_clock_pos, sample_clock_neg, sleep_select_n,
                       sleep_select_driven, data_pos, data_neg};

    // Two stages for every pin; the first stage feeds only the second
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // ************************************************************
    // Pin decode
    // ************************************************************
    logic             clk_p_s;
    logic             clk_n_s;
    logic             sel_s;
    logic             drv_s;
    logic [WIDTH-1:0] dpos_s;
    logic [WIDTH-1:0] dneg_s;
    logic [WIDTH-1:0] word_in;
    logic             clk_valid;
    logic             clk_level;
    logic             sel_eff;

    assign clk_p_s   = sync2_reg[SYNC_W-1];
    assign clk_n_s   = sync2_reg[SYNC_W-2];
    assign sel_s     = sync2_reg[SYNC_W-3];
    assign drv_s     = sync2_reg[SYNC_W-4];
    assign dpos_s    = sync2_reg[2*WIDTH-1:WIDTH];
    assign dneg_s    = sync2_reg[WIDTH-1:0];
    // Bit i of the pair bus stays bit i of the word, MSB on top
    assign word_in   = dpos_s & ~dneg_s;
    // A pair at equal levels is no valid clock level; keep the last one
    assign clk_valid = clk_p_s ^ clk_n_s;
    assign clk_level = clk_p_s;
    // An undriven select floats high through the pull-up
    assign sel_eff   = drv_s ? sel_s : SLEEP_PULL_LEVEL;

    // ************************************************************
    // Mode control
    // ************************************************************
    mode_t mode_reg;
    mode_t mode_next;
    logic  active;

    always_comb begin
        unique case (sel_eff)
            1'b0: mode_next = MODE_SLEEP;
            1'b1: mode_next = MODE_ACTIVE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= MODE_ACTIVE;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign active       = (mode_reg == MODE_ACTIVE);
    assign sleep_active = (mode_reg == MODE_SLEEP);

    // ************************************************************
    // Sample clock edge detection
    // ************************************************************
    logic clk_prev_reg;
    logic rise;
    logic fall;
    logic edge_evt;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clk_prev_reg <= 1'b0;
        end else if (clk_valid) begin
            clk_prev_reg <= clk_level;
        end
    end

    // Both edges load a word; one word per edge bounds each channel's rate
    assign rise     = clk_valid & clk_level & ~clk_prev_reg;
    assign fall     = clk_valid & ~clk_level & clk_prev_reg;
    assign edge_evt = rise | fall;

    // ************************************************************
    // Latency pipeline, advanced by sample clock edges
    // ************************************************************
    logic [WIDTH-1:0] stage_word [LATENCY_EDGES];
    chan_t            stage_chan [LATENCY_EDGES];
    logic             stage_vld  [LATENCY_EDGES];
    chan_t            cap_chan;
    logic             pipe_out;
    logic             a_load;
    logic             b_load;

    // Rising edge words go to A, falling edge words to B
    assign cap_chan = rise ? CHAN_A : CHAN_B;
    // The word leaves on the third edge after its own: 1.5 clock cycles
    assign pipe_out = edge_evt & active & stage_vld[LATENCY_EDGES-1];
    assign a_load   = pipe_out & (stage_chan[LATENCY_EDGES-1] == CHAN_A);
    assign b_load   = pipe_out & (stage_chan[LATENCY_EDGES-1] == CHAN_B);

    // Sleep flushes the pipeline so stale words never reach an output
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < LATENCY_EDGES; i++) begin
                stage_word[i] <= '0;
                stage_chan[i] <= CHAN_A;
                stage_vld[i]  <= 1'b0;
            end
        end else if (!active) begin
            for (int i = 0; i < LATENCY_EDGES; i++) begin
                stage_vld[i] <= 1'b0;
            end
        end else if (edge_evt) begin
            stage_word[0] <= word_in;
            stage_chan[0] <= cap_chan;
            stage_vld[0]  <= 1'b1;
            for (int i = 1; i < LATENCY_EDGES; i++) begin
                stage_word[i] <= stage_word[i-1];
                stage_chan[i] <= stage_chan[i-1];
                stage_vld[i]  <= stage_vld[i-1];
            end
        end
    end

    // ************************************************************
    // Channel output stages
    // ************************************************************
    chan_load_if #(.WIDTH(WIDTH)) link_a ();
    chan_load_if #(.WIDTH(WIDTH)) link_b ();

    assign link_a.word  = stage_word[LATENCY_EDGES-1];
    assign link_a.load  = a_load;
    assign link_a.sleep = sleep_active;
    assign link_b.word  = stage_word[LATENCY_EDGES-1];
    assign link_b.load  = b_load;
    assign link_b.sleep = sleep_active;

    chan_current_out #(.WIDTH(WIDTH)) out_a (
        .core_clk (core_clk),
        .nrst     (nrst),
        .link     (link_a),
        .sink_pos (chan_a_current_pos),
        .sink_neg (chan_a_current_neg)
    );

    chan_current_out #(.WIDTH(WIDTH)) out_b (
        .core_clk (core_clk),
        .nrst     (nrst),
        .link     (link_b),
        .sink_pos (chan_b_current_pos),
        .sink_neg (chan_b_current_neg)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    // Helper: edges seen since the last sleep, saturating at the latency
    logic [1:0] edges_awake_reg;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            edges_awake_reg <= 2'h0;
        end else if (!active) begin
            edges_awake_reg <= 2'h0;
        end else if (edge_evt && edges_awake_reg != 2'h3) begin
            edges_awake_reg <= edges_awake_reg + 2'h1;
        end
    end

    sequence cap_rise_s;
        rise && active;
    endsequence

    sequence cap_fall_s;
        fall && active;
    endsequence

    width_legal_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        WIDTH == WIDTH_NARROW || WIDTH == WIDTH_MID || WIDTH == WIDTH_WIDE)
        else $error("Word width is not one of the allowed builds");

    edge_capture_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (edge_evt && active) |=>
            stage_vld[0] && (stage_word[0] == $past(word_in)))
        else $error("Sample clock edge did not capture the bus word");

    rise_to_a_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        cap_rise_s |=> (stage_chan[0] == CHAN_A))
        else $error("Rising edge word not tagged for channel A");

    fall_to_b_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        cap_fall_s |=> (stage_chan[0] == CHAN_B))
        else $error("Falling edge word not tagged for channel B");

    steer_a_only_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (a_load && active && mode_next == MODE_ACTIVE) |=>
            (chan_a_current_neg == $past(stage_word[LATENCY_EDGES-1]))
            && $stable(chan_b_current_neg))
        else $error("Channel A word not steered to channel A alone");

    msb_order_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (edge_evt && active) |=>
            (stage_word[0][WIDTH-1] == $past(dpos_s[WIDTH-1] & ~dneg_s[WIDTH-1]))
            && (stage_word[0][0] == $past(dpos_s[0] & ~dneg_s[0])))
        else $error("Bus bit order not kept in captured word");

    sleep_enter_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (drv_s && !sel_s) |=> sleep_active ##1 (chan_a_current_pos == '0))
        else $error("Low sleep select did not enter sleep");

    pull_up_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !drv_s |=> !sleep_active)
        else $error("Undriven sleep select did not give active mode");

    latency_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        pipe_out |-> (edges_awake_reg == 2'h3))
        else $error("Word left the pipeline before three edges");

endmodule : ddr_dac_input

`default_nettype wire

// ### tb/word_source.sv
/*
 * Behavioural sample source: drives the sample clock pair and the shared
 * data bus, one new word per sample clock edge.
 * Assumes it is paced by the core clock and that calls start 1 ns after
 * a rising core clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module word_source #(
    parameter int WIDTH = 14
) (
    // Pacing clock
    input  wire logic             core_clk,
    // Sample clock pair and data bus
    output logic                  clk_pos,
    output logic                  clk_neg,
    output logic [WIDTH-1:0]      dat_pos,
    output logic [WIDTH-1:0]      dat_neg
);
    // Long half period keeps the rate far below both limits
    localparam int HALF = 6;
    localparam int HOLD = 4;

    // Clock idles low so the first edge of a stream is a rising one
    initial begin
        clk_pos = 1'b0;
        clk_neg = 1'b1;
        dat_pos = '0;
        dat_neg = '1;
    end

    // One edge, one word; bit i of the bus is bit i of the word
    task automatic send(input logic [WIDTH-1:0] w);
        clk_pos = ~clk_pos;
        clk_neg = ~clk_pos;
        dat_pos = w;
        dat_neg = ~w;
        repeat (HOLD) @(posedge core_clk);
        #1;
        // Hold time over: show garbage so stale data cannot pass
        dat_pos = ~w;
        dat_neg = w;
        repeat (HALF - HOLD) @(posedge core_clk);
        #1;
    endtask : send

    // Equal-level clock pair for a while; must not count as an edge
    task automatic glitch();
        clk_neg = clk_pos;
        repeat (4) @(posedge core_clk);
        #1;
        clk_neg = ~clk_pos;
        // Let an edge pass so a following send never reassigns clk_neg at once
        @(posedge core_clk);
        #1;
    endtask : glitch
endmodule : word_source

`default_nettype wire

// ### tb/testbench.sv
/*
 * Self-checking bench for the interleaved converter input, at widths
 * 14 and 10 side by side on one source.
 * Assumes the latency and sleep timing of the design as built.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import ddr_dac_pkg::*;
    localparam int WW = WIDTH_WIDE;
    localparam int NW = WIDTH_NARROW;
    // About 2 us of 4 ns core cycles for the outputs to settle after wake
    localparam int WAKE_SETTLE = 500;

    logic          core_clk;
    logic          nrst;
    logic          clk_pos;
    logic          clk_neg;
    logic          sel_n;
    logic          sel_drv;
    logic [WW-1:0] dat_pos;
    logic [WW-1:0] dat_neg;
    logic [WW-1:0] w_out [4];
    logic [NW-1:0] n_out [4];
    logic          w_sleep;
    logic          n_sleep;
    logic [WW-1:0] hist [$];
    logic [WW-1:0] ea;
    logic [WW-1:0] eb;
    logic          va;
    logic          vb;
    logic          asleep;
    logic [15:0]   seed;
    int            fails;
    int            n_compared;

    // ************************************************************
    // Clock, source and devices
    // ************************************************************
    always #2 core_clk = ~core_clk;

    word_source #(.WIDTH(WW)) word_source_i (
        .core_clk(core_clk), .clk_pos(clk_pos), .clk_neg(clk_neg),
        .dat_pos(dat_pos), .dat_neg(dat_neg));

    ddr_dac_input #(.WIDTH(WW)) ddr_dac_input_i (
        .core_clk(core_clk), .nrst(nrst),
        .sample_clock_pos(clk_pos), .sample_clock_neg(clk_neg),
        .data_pos(dat_pos), .data_neg(dat_neg),
        .sleep_select_n(sel_n), .sleep_select_driven(sel_drv),
        .chan_a_current_pos(w_out[0]), .chan_a_current_neg(w_out[1]),
        .chan_b_current_pos(w_out[2]), .chan_b_current_neg(w_out[3]),
        .sleep_active(w_sleep));

    // Narrow build sees the low bus bits only
    ddr_dac_input #(.WIDTH(NW)) ddr_dac_input_narrow_i (
        .core_clk(core_clk), .nrst(nrst),
        .sample_clock_pos(clk_pos), .sample_clock_neg(clk_neg),
        .data_pos(dat_pos[NW-1:0]), .data_neg(dat_neg[NW-1:0]),
        .sleep_select_n(sel_n), .sleep_select_driven(sel_drv),
        .chan_a_current_pos(n_out[0]), .chan_a_current_neg(n_out[1]),
        .chan_b_current_pos(n_out[2]), .chan_b_current_neg(n_out[3]),
        .sleep_active(n_sleep));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Sink code: positive leg is the inverted word, empty channel is 0
    function automatic logic [WW-1:0] code(input logic v,
        input logic [WW-1:0] w, input logic inv);
        if (!v) return '0;
        return inv ? ~w : w;
    endfunction : code

    task automatic check(input logic [WW-1:0] seen, input logic [WW-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic check_all();
        logic [WW-1:0] e [4];
        e[0] = code(va, ea, 1'b1);
        e[1] = code(va, ea, 1'b0);
        e[2] = code(vb, eb, 1'b1);
        e[3] = code(vb, eb, 1'b0);
        for (int i = 0; i < 4; i++) begin
            check(w_out[i], e[i]);
            check({4'h0, n_out[i]}, {4'h0, e[i][NW-1:0]});
        end
    endtask : check_all

    // Send one word; the word 3 edges back is now on its channel
    task automatic push(input logic [WW-1:0] w);
        int j;
        word_source_i.send(w);
        if (!asleep) begin
            hist.push_back(w);
            j = hist.size() - 1 - LATENCY_EDGES;
            if (j >= 0 && j % 2 == 0) begin
                va = 1'b1;
                ea = hist[j];
            end else if (j >= 0) begin
                vb = 1'b1;
                eb = hist[j];
            end
        end
        check_all();
    endtask : push

    // Even counts only, so each stream starts on a rising edge
    task automatic stream(input int n);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            push(seed[WW-1:0]);
        end
    endtask : stream

    task automatic set_pin(input logic sel, input logic drv, input logic slp);
        sel_n = sel;
        sel_drv = drv;
        repeat (5) @(posedge core_clk);
        #1;
        if (slp) begin
            asleep = 1'b1;
            va = 1'b0;
            vb = 1'b0;
            hist.delete();
        end else begin
            asleep = 1'b0;
        end
        check({13'h0, w_sleep}, {13'h0, slp});
        check({13'h0, n_sleep}, {13'h0, slp});
        check_all();
    endtask : set_pin

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        sel_n = 1'b1;
        sel_drv = 1'b1;
        seed = 16'h0032;
        fails = 0;
        n_compared = 0;
        va = 1'b0;
        vb = 1'b0;
        ea = '0;
        eb = '0;
        asleep = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        set_pin(1'b1, 1'b1, 1'b0);
        // Full-scale corners first, then random traffic
        push('0);
        push('1);
        push('1);
        push('0);
        stream(20);
        // Equal-level pair must not be taken as an edge
        word_source_i.glitch();
        check_all();
        stream(2);
        // Floating select reads high through the pull-up
        set_pin(1'b0, 1'b0, 1'b0);
        stream(4);
        // Sleep: bus ignored, both channels at zero
        set_pin(1'b0, 1'b1, 1'b1);
        stream(4);
        // Wake: pipeline refills from empty
        set_pin(1'b1, 1'b1, 1'b0);
        repeat (WAKE_SETTLE) @(posedge core_clk);
        #1;
        stream(10);
        close_out();
    end

    // Whole run is about 800 cycles; far beyond that means a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        close_out();
    end
endmodule : testbench

`default_nettype wire
